// *** rtl/cptm_core.sv ***
// compact 16-bit timer: compare match, timer/counter and PWM modes
// assumes TICK is a one-cycle timer clock enable from REF_CLK logic
// and that all control bits come from registers on the same clock
`timescale 1ns/1ps
`include "cptm_map.svh"
module cptm_core
  import cptm_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic SRST,
  input wire logic TICK,
  input wire logic COUNTER_ENABLE,
  input wire logic MODE_SELECT_HI,
  input wire logic MODE_SELECT_LO,
  input wire logic OUTPUT_FUNCTION_HI,
  input wire logic OUTPUT_FUNCTION_LO,
  input wire logic OUTPUT_CONTROL_BIT,
  input wire logic OUTPUT_POLARITY_BIT,
  input wire logic DUTY_PERIOD_SWAP,
  input wire logic CLEAR_SOURCE_SELECT,
  input wire logic [15:0] COMPARATOR_A_VALUE,
  input wire logic [7:0] PERIOD_COMPARE_VALUE,
  input wire logic FLAG_A_CLEAR,
  input wire logic FLAG_P_CLEAR,
  output logic [15:0] COUNT,
  output logic COMPARATOR_A_FLAG,
  output logic COMPARATOR_P_FLAG,
  output logic PIN_OUT,
  output logic PIN_OE_N
);

  // p value scaled to ticks; zero stands for a full 16-bit span
  function automatic cptm_span_t p_span(input cptm_period_t p);
    cptm_span_t s;
    s = (p == '0) ? `CPTM_FULL_SPAN : {1'b0, p, `CPTM_LOW_ZERO};
    return s;
  endfunction : p_span

  logic en_d;
  logic cmp_pin;
  cptm_count_t next_count;
  logic next_flag_a;
  logic next_flag_p;
  logic next_cmp_pin;
  logic next_pin;
  logic next_oe_n;

  wire cptm_mode_t mode = {MODE_SELECT_HI, MODE_SELECT_LO};
  wire cptm_func_t func = {OUTPUT_FUNCTION_HI, OUTPUT_FUNCTION_LO};

  wire mode_cmp = (mode == `CPTM_MODE_CMP);
  wire mode_pwm = (mode == `CPTM_MODE_PWM);
  // timer and the undefined code share the compare counting path
  wire mode_cnt_only = (mode == `CPTM_MODE_TMR) || (mode == `CPTM_MODE_UNDEF);

  wire en_rise = COUNTER_ENABLE & ~en_d;
  wire tick_go = COUNTER_ENABLE & ~en_rise & TICK;
  wire cptm_count_t count_inc = COUNT + 16'h0001;

  wire a_eq;
  wire p_eq;
  wire a_zero;

  cptm_cmp #(
    .CNT_W(`CPTM_CNT_W),
    .P_W(`CPTM_P_W)
  ) u_cmp (
    .count_inc(count_inc),
    .a_val(COMPARATOR_A_VALUE),
    .p_val(PERIOD_COMPARE_VALUE),
    .a_eq(a_eq),
    .p_eq(p_eq),
    .a_zero(a_zero)
  );

  // an all-zero A value never matches; the counter just wraps at FFFF
  wire a_hit = tick_go & a_eq & ~a_zero;
  // p value zero matches at the wrap, i.e. the overflow case
  wire p_hit = tick_go & p_eq;

  // compare-like modes choose the clear source by the select bit
  wire clr_cmp = CLEAR_SOURCE_SELECT ? a_hit : p_hit;
  // pwm looks at the swap bit only
  wire clr_pwm = DUTY_PERIOD_SWAP ? a_hit : p_hit;
  wire clr = mode_pwm ? clr_pwm : clr_cmp;

  wire set_a = a_hit;
  // no P flag at all while A clears the counter outside pwm
  wire set_p = p_hit & (mode_pwm | ~CLEAR_SOURCE_SELECT);

  wire cptm_span_t a_span = a_zero ? `CPTM_FULL_SPAN : {1'b0, COMPARATOR_A_VALUE};
  wire cptm_span_t p_ticks = p_span(PERIOD_COMPARE_VALUE);
  wire cptm_span_t period_val = DUTY_PERIOD_SWAP ? a_span : p_ticks;
  wire cptm_span_t duty_val = DUTY_PERIOD_SWAP ? p_ticks :
                              {1'b0, COMPARATOR_A_VALUE};
  // the counter never passes the period, so duty >= period keeps it active
  wire pwm_on = ({1'b0, COUNT} < duty_val);
  wire pwm_wave = pwm_on ? OUTPUT_CONTROL_BIT : ~OUTPUT_CONTROL_BIT;

  // counting keeps going whatever the function bits force
  logic pwm_level;
  always_comb begin
    pwm_level = ~OUTPUT_CONTROL_BIT;
    case (func)
      `CPTM_PWM_INACT: pwm_level = ~OUTPUT_CONTROL_BIT;
      `CPTM_PWM_ACT: pwm_level = OUTPUT_CONTROL_BIT;
      `CPTM_PWM_WAVE: pwm_level = pwm_wave;
      default: pwm_level = ~OUTPUT_CONTROL_BIT;
    endcase
  end

  // compare-mode pin state moves only on an A match or an enable rise
  always_comb begin
    next_cmp_pin = cmp_pin;
    if (en_rise) begin
      next_cmp_pin = OUTPUT_CONTROL_BIT;
    end else if (mode_cmp && a_hit) begin
      case (func)
        `CPTM_FN_NONE: next_cmp_pin = cmp_pin;
        `CPTM_FN_LOW: next_cmp_pin = 1'b0;
        `CPTM_FN_HIGH: next_cmp_pin = 1'b1;
        `CPTM_FN_TOG: next_cmp_pin = ~cmp_pin;
        default: next_cmp_pin = cmp_pin;
      endcase
    end
  end

  always_comb begin
    next_count = COUNT;
    if (en_rise) begin
      next_count = `CPTM_RST_COUNT;
    end else if (tick_go) begin
      next_count = clr ? `CPTM_RST_COUNT : count_inc;
    end
  end

  // a set in the same cycle as a clear wins
  assign next_flag_a = (COMPARATOR_A_FLAG & ~FLAG_A_CLEAR) | set_a;
  assign next_flag_p = (COMPARATOR_P_FLAG & ~FLAG_P_CLEAR) | set_p;

  wire drive_pin = mode_cmp | mode_pwm;
  wire level = mode_pwm ? pwm_level : cmp_pin;
  // polarity acts in both driving modes; the pin reads 0 while released
  assign next_pin = drive_pin ? (level ^ OUTPUT_POLARITY_BIT) : 1'b0;
  assign next_oe_n = ~drive_pin;

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      en_d <= 1'b0;
      COUNT <= `CPTM_RST_COUNT;
      cmp_pin <= 1'b0;
      COMPARATOR_A_FLAG <= 1'b0;
      COMPARATOR_P_FLAG <= 1'b0;
    end else begin
      en_d <= COUNTER_ENABLE;
      COUNT <= next_count;
      cmp_pin <= next_cmp_pin;
      COMPARATOR_A_FLAG <= next_flag_a;
      COMPARATOR_P_FLAG <= next_flag_p;
    end
  end

  // pin is registered, so it trails the counter by one cycle
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      PIN_OUT <= 1'b0;
      PIN_OE_N <= 1'b1;
    end else begin
      PIN_OUT <= next_pin;
      PIN_OE_N <= next_oe_n;
    end
  end

  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (SRST);

  chk_enable_rise_zero: assert property (
    en_rise |=> (COUNT == `CPTM_RST_COUNT))
    else $error("counter not zeroed on enable rise");

  chk_count_hold_off: assert property (
    !COUNTER_ENABLE |=> (COUNT == $past(COUNT)))
    else $error("counter moved while disabled");

  chk_count_step_up: assert property (
    (tick_go && !clr) |=> (COUNT == 16'($past(COUNT) + 16'h0001)))
    else $error("counter did not step by one");

  chk_p_match_clear: assert property (
    (tick_go && !mode_pwm && !CLEAR_SOURCE_SELECT && p_eq)
      |=> (COUNT == `CPTM_RST_COUNT) && COMPARATOR_P_FLAG)
    else $error("P match did not clear or flag");

  chk_no_p_flag: assert property (
    (!mode_pwm && CLEAR_SOURCE_SELECT && !COMPARATOR_P_FLAG)
      |=> !COMPARATOR_P_FLAG)
    else $error("P flag raised while A clears");

  chk_a_zero_wrap: assert property (
    (tick_go && !mode_pwm && CLEAR_SOURCE_SELECT && a_zero
      && !COMPARATOR_A_FLAG && COUNT == 16'hffff)
      |=> (COUNT == `CPTM_RST_COUNT) && !COMPARATOR_A_FLAG)
    else $error("zero A value flagged or failed to wrap");

  chk_pin_only_a: assert property (
    (mode_cmp && !a_hit && !en_rise) |=> (cmp_pin == $past(cmp_pin)))
    else $error("compare pin changed without A match");

  chk_toggle_on_a: assert property (
    (mode_cmp && a_hit && !en_rise && func == `CPTM_FN_TOG)
      |=> (cmp_pin != $past(cmp_pin))
      ##1 (PIN_OUT == ($past(cmp_pin) ^ $past(OUTPUT_POLARITY_BIT))))
    else $error("toggle function did not toggle pin");

  chk_initial_level: assert property (
    en_rise |=> (cmp_pin == $past(OUTPUT_CONTROL_BIT)))
    else $error("pin not loaded with initial level");

  chk_timer_release: assert property (
    (mode == `CPTM_MODE_TMR) |=> PIN_OE_N && !PIN_OUT)
    else $error("pin driven in timer mode");

  chk_pwm_full_duty: assert property (
    (mode_pwm && func == `CPTM_PWM_WAVE && duty_val >= period_val
      && {1'b0, COUNT} < period_val)
      |=> (PIN_OUT == ($past(OUTPUT_CONTROL_BIT) ^ $past(OUTPUT_POLARITY_BIT))))
    else $error("full duty not held active");

  chk_pwm_flags_both: assert property (
    (mode_pwm && p_hit && a_hit) |=> COMPARATOR_A_FLAG && COMPARATOR_P_FLAG)
    else $error("pwm flags not raised together");

  chk_flag_set_wins: assert property (
    (set_a && FLAG_A_CLEAR) |=> COMPARATOR_A_FLAG)
    else $error("clear beat a flag set");

  chk_cmp_pin_drive: assert property (
    mode_cmp |=> !PIN_OE_N && (PIN_OUT == ($past(cmp_pin) ^ $past(OUTPUT_POLARITY_BIT))))
    else $error("compare pin not driven from its state");

  chk_released_modes: assert property (
    mode_cnt_only |=> PIN_OE_N && !PIN_OUT)
    else $error("pin driven in a counting-only mode");

  chk_a_flag_set: assert property (
    a_hit |=> COMPARATOR_A_FLAG)
    else $error("A match did not raise A flag");

  chk_p_flag_set: assert property (
    (p_hit && (mode_pwm || !CLEAR_SOURCE_SELECT)) |=> COMPARATOR_P_FLAG)
    else $error("P match did not raise P flag");

  chk_a_match_clear: assert property (
    (!mode_pwm && CLEAR_SOURCE_SELECT && a_hit) |=> (COUNT == `CPTM_RST_COUNT))
    else $error("A match did not clear the counter");

  chk_pwm_period_p: assert property (
    (mode_pwm && !DUTY_PERIOD_SWAP && p_hit) |=> (COUNT == `CPTM_RST_COUNT))
    else $error("pwm P period did not clear");

  chk_pwm_period_a: assert property (
    (mode_pwm && DUTY_PERIOD_SWAP && a_hit) |=> (COUNT == `CPTM_RST_COUNT))
    else $error("pwm A period did not clear");

  chk_pwm_keep_count: assert property (
    (mode_pwm && !DUTY_PERIOD_SWAP && a_hit && !p_hit)
      |=> (COUNT == 16'($past(COUNT) + 16'h0001)))
    else $error("duty match cleared the pwm counter");

  chk_pwm_forced_act: assert property (
    (mode_pwm && func == `CPTM_PWM_ACT)
      |=> !PIN_OE_N && (PIN_OUT == ($past(OUTPUT_CONTROL_BIT) ^ $past(OUTPUT_POLARITY_BIT))))
    else $error("forced active level wrong");

  chk_pwm_forced_inact: assert property (
    (mode_pwm && func == `CPTM_PWM_INACT)
      |=> (PIN_OUT == (!$past(OUTPUT_CONTROL_BIT) ^ $past(OUTPUT_POLARITY_BIT))))
    else $error("forced inactive level wrong");

  chk_pwm_wave_level: assert property (
    (mode_pwm && func == `CPTM_PWM_WAVE)
      |=> (PIN_OUT == ((({1'b0, $past(COUNT)} < $past(duty_val)) == $past(OUTPUT_CONTROL_BIT))
      ^ $past(OUTPUT_POLARITY_BIT))))
    else $error("pwm wave level wrong");

  chk_p_set_wins: assert property (
    (set_p && FLAG_P_CLEAR) |=> COMPARATOR_P_FLAG)
    else $error("clear beat a P flag set");

  cov_cmp_toggle: cover property (
    mode_cmp && a_hit && func == `CPTM_FN_TOG);

  cov_pwm_full: cover property (
    mode_pwm && duty_val >= period_val && tick_go);

  cov_a_overflow: cover property (
    tick_go && CLEAR_SOURCE_SELECT && a_zero && COUNT == 16'hffff);

  cov_pwm_swap_clear: cover property (
    mode_pwm && DUTY_PERIOD_SWAP && a_hit);

  cov_timer_p_match: cover property (
    mode_cnt_only && p_hit);

endmodule : cptm_core

// *** shared/cptm_map.svh ***
// constants for the compact timer: mode codes, output functions, widths
// assumes it is included by bare name from the rtl files
// Notes on behaviour
// - mode 00 is compare match output; clear by overflow, A match or P match
// - clear source low clears on P match; P value zero lets counter overflow
// - compare mode, clear source low: both A and P flags are raised
// - clear source high clears on A match, raises only A flag, never P
// - clear source high with A value zero: overflow at FFFF, no A flag
// - compare mode: only an A match or an enable rise changes the pin, P match never does
// - on A match the pin goes high, low or toggles; 00 means no change
// - enable rising edge loads the pin with the output control level
// - mode 11 counts and flags like compare mode but releases the pin
// - mode 10 is PWM output, fixed period, programmable duty on the pin
// - PWM ignores clear source select; swap bit alone picks clearing
// - swap 0: period is P times 256 or 65536; duty is A value
// - swap 1: period is A value; duty is P times 256 or 65536
// - duty equal to or above period gives 100% duty
// - PWM raises A and P flags independently on their matches
// - PWM: control bit sets active level; function bits enable or force
// - polarity bit inverts the output waveform
// - PWM counting continues while function bits force a fixed level
// - enable rise zeroes the counter; enable low holds residual value
// - P value compares with the upper eight counter bits; the low eight must be zero
`ifndef CPTM_MAP_SVH
`define CPTM_MAP_SVH

`define CPTM_CNT_W 16
`define CPTM_P_W 8
`define CPTM_RST_COUNT 16'h0000
`define CPTM_FULL_SPAN 17'h10000
`define CPTM_LOW_ZERO 8'h00

`define CPTM_MODE_CMP 2'b00
`define CPTM_MODE_UNDEF 2'b01
`define CPTM_MODE_PWM 2'b10
`define CPTM_MODE_TMR 2'b11

`define CPTM_FN_NONE 2'b00
`define CPTM_FN_LOW 2'b01
`define CPTM_FN_HIGH 2'b10
`define CPTM_FN_TOG 2'b11

`define CPTM_PWM_INACT 2'b00
`define CPTM_PWM_ACT 2'b01
`define CPTM_PWM_WAVE 2'b10

`endif

// *** shared/cptm_pkg.sv ***
// types shared by the compact timer rtl
// assumes cptm_map.svh supplies the numeric constants
package cptm_pkg;
  typedef logic [1:0] cptm_mode_t;
  typedef logic [1:0] cptm_func_t;
  typedef logic [15:0] cptm_count_t;
  typedef logic [7:0] cptm_period_t;
  typedef logic [16:0] cptm_span_t;
endpackage : cptm_pkg

// *** rtl/cptm_cmp.sv ***
// comparator pair for the compact timer
// assumes the caller hands in the counter value it is about to load
`timescale 1ns/1ps
module cptm_cmp #(
  parameter int CNT_W = 16,
  parameter int P_W = 8
) (
  input wire logic [CNT_W-1:0] count_inc,
  input wire logic [CNT_W-1:0] a_val,
  input wire logic [P_W-1:0] p_val,
  output logic a_eq,
  output logic p_eq,
  output logic a_zero
);
  localparam int LOW_W = CNT_W - P_W;

  wire [LOW_W-1:0] low_bits = count_inc[LOW_W-1:0];
  wire [P_W-1:0] high_bits = count_inc[CNT_W-1:LOW_W];

  assign a_eq = (count_inc == a_val);
  // top bits are compared with p and the low bits must be zero, so P matches land on 256-tick steps
  assign p_eq = (high_bits == p_val) && (low_bits == '0);
  assign a_zero = (a_val == '0);
endmodule : cptm_cmp

// *** verif/tb_top.sv ***
// self-checking bench for cptm_core: a cycle model runs beside the design
// assumes cptm_pkg is compiled first; the design's assertions live in the rtl
`timescale 1ns/1ps
module tb_top;
  import cptm_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic tick = 1'b0, en = 1'b0, mh = 1'b0, ml = 1'b0, fh = 1'b0, fl = 1'b0;
  logic oc = 1'b0, pol = 1'b0, swp = 1'b0, ccs = 1'b0, fca = 1'b0, fcp = 1'b0;
  logic chk_on = 1'b0;
  cptm_count_t av = 16'h0000;
  cptm_period_t pv = 8'h00;
  cptm_count_t cnt;
  logic fa, fp, pin, oe_n;
  cptm_count_t m_cnt, inc;
  logic m_fa, m_fp, m_st, m_pin, m_oe_n, m_pe, am, pm, pwm;
  logic [31:0] r;
  // mode, function, oc, pol, swap, clear source, a value, p value
  logic [31:0] corner [8] = '{32'h3100_0000, 32'h3500_0300, 32'h2000_4001, 32'ha801_8001,
    32'hae03_0001, 32'h9000_5002, 32'hf000_2001, 32'h8900_4001};
  int miscompares = 0;
  int n_checks = 0;
  always #12.5 clk = ~clk;
  cptm_core dut (.REF_CLK(clk), .SRST(srst), .TICK(tick), .COUNTER_ENABLE(en),
    .MODE_SELECT_HI(mh), .MODE_SELECT_LO(ml), .OUTPUT_FUNCTION_HI(fh),
    .OUTPUT_FUNCTION_LO(fl), .OUTPUT_CONTROL_BIT(oc), .OUTPUT_POLARITY_BIT(pol),
    .DUTY_PERIOD_SWAP(swp), .CLEAR_SOURCE_SELECT(ccs), .COMPARATOR_A_VALUE(av),
    .PERIOD_COMPARE_VALUE(pv), .FLAG_A_CLEAR(fca), .FLAG_P_CLEAR(fcp), .COUNT(cnt),
    .COMPARATOR_A_FLAG(fa), .COMPARATOR_P_FLAG(fp), .PIN_OUT(pin), .PIN_OE_N(oe_n));
  function automatic logic pwm_lvl(input cptm_count_t c);
    cptm_span_t d, p;
    logic act;
    d = swp ? (pv == 8'h00 ? 17'h10000 : {1'b0, pv, 8'h00}) : {1'b0, av};
    p = swp ? (av == 16'h0000 ? 17'h10000 : {1'b0, av}) : (pv == 8'h00 ? 17'h10000 : {1'b0, pv, 8'h00});
    act = ({1'b0, c} < d) || (d >= p);
    case ({fh, fl})
      2'b01: pwm_lvl = oc ^ pol;
      2'b10: pwm_lvl = (act ? oc : ~oc) ^ pol;
      default: pwm_lvl = ~oc ^ pol;
    endcase
  endfunction : pwm_lvl
  // reference model; samples inputs before the bench's updates at the same edge land
  always @(posedge clk) begin
    inc = m_cnt + 16'h0001;
    pwm = mh & ~ml;
    am = en && m_pe && tick && inc == av && av != 16'h0000;
    pm = en && m_pe && tick && inc[7:0] == 8'h00 && inc[15:8] == pv;
    if (srst) begin
      {m_cnt, m_fa, m_fp, m_st, m_pin, m_oe_n, m_pe} <= {16'h0000, 6'h02};
    end else begin
      m_pe <= en;
      if (en && !m_pe) begin
        m_cnt <= 16'h0000;
        m_st <= oc;
      end else if (en && tick) begin
        m_cnt <= ((pwm ? swp : ccs) ? am : pm) ? 16'h0000 : inc;
        if (am && !pwm) begin
          case ({fh, fl})
            2'b01: m_st <= 1'b0;
            2'b10: m_st <= 1'b1;
            2'b11: m_st <= ~m_st;
            default: ;
          endcase
        end
      end
      m_fa <= (m_fa & ~fca) | am;
      m_fp <= (m_fp & ~fcp) | (pm & (pwm | ~ccs));
      m_oe_n <= ml;
      m_pin <= ml ? 1'b0 : (pwm ? pwm_lvl(m_cnt) : m_st ^ pol);
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  always @(negedge clk) begin
    if (chk_on) begin
      check(cnt, m_cnt);
      check({15'h0000, fa}, {15'h0000, m_fa});
      check({15'h0000, fp}, {15'h0000, m_fp});
      check({15'h0000, pin}, {15'h0000, m_pin});
      check({15'h0000, oe_n}, {15'h0000, m_oe_n});
    end
  end
  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_of_test
  initial begin
    int t;
    void'($urandom(32'h1749));
    repeat (2) @(posedge clk);
    chk_on <= 1'b1;
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    for (t = 0; t < 16; t++) begin
      @(posedge clk);
      en <= 1'b0; // function bits change only while stopped
      @(posedge clk);
      r = $urandom;
      if (t < 8) begin
        {mh, ml, fh, fl, oc, pol, swp, ccs, av, pv} <= corner[t];
      end else begin
        {mh, ml, fh, fl, oc, pol, swp, ccs} <= r[7:0];
        av <= {6'h00, r[17:8]};
        pv <= {6'h00, r[19:18]};
      end
      @(posedge clk);
      en <= 1'b1;
      // first case runs to the 16-bit wrap with ticks every cycle
      repeat (t == 0 ? 66000 : 1200) begin
        @(posedge clk);
        r = $urandom;
        tick <= (t == 0) || (r[1:0] != 2'b00);
        en <= (t == 0) || (r[9:2] != 8'h00);
        fca <= r[13:10] == 4'h0;
        fcp <= r[17:14] == 4'h0;
      end
      $display("test %0d done, mismatches %0d", t, miscompares);
    end
    end_of_test();
  end
endmodule : tb_top
